/* logic/csmr_mode_bank.sv */
// clock source selection and serial mode/status register bank
`timescale 1ns/1ps
// Summary of operation
// - both selects 0: oscillator everywhere, output 9 out
// - pll select 1: aux feeds pll, osc outputs
// - output select 1: osc feeds pll, aux outputs
// - both 1: aux feeds pll and outputs
// - mode register volatile, addressed by code 12
// - bit 8 reads aux clock detect
// - bit 9 reads oscillator clock detect
// - bit 10 reads pll lock
// - bit 11 low means power down, resets high
// - bit 12 low forces reset or hold
// - bit 13 test enable, resets 0, gates tests
// - bits 14..16 read-only revision code
// - bit 17 under test disables io and dividers
// - bit 18 low: status pin drives cmos
// - bit 19 under test routes hold to lock
// - bits 21..24 select status pin signal
// - config bit selects hold (1) or reset (0)
module csmr_mode_bank
  import csmr_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial link from the host
  input wire logic spiClk,
  input wire logic spiLatch,
  input wire logic spiDataIn,
  output logic spiDataOut,
  // stored configuration bits held outside this block
  input wire logic pllSourceSelect,
  input wire logic outSourceSelect,
  input wire logic holdFunctionSelect,
  // analog status levels, asynchronous
  input wire logic auxClockDetect,
  input wire logic oscClockDetect,
  input wire logic pllLockRaw,
  input wire logic refClockDetect,
  input wire logic refPrimarySelected,
  // clock source steering
  output logic pllFeedFromAux,
  output logic outputsFromAux,
  output logic detBlockFromAux,
  output logic output9Enable,
  output logic auxInputEnable,
  output logic oscInputEnable,
  output logic outputBuffersEnable,
  output logic dividersEnable,
  // device controls
  output logic powerDown,
  output logic resetAssert,
  output logic holdAssert,
  // indicator pins
  output logic lockPin,
  output logic statusPinOut,
  output logic statusPinOutEn_n,
  output logic currentRefResistor
);

  // ****************************************
  // link domain: frame shifter
  // ****************************************
  logic [31:0] rxWord;
  logic [5:0] rxCount;
  logic [30:0] txShift;
  logic misoBit;
  logic [31:0] readImage;

  // shift in least significant bit first while the latch is low;
  // the counter saturates one past a full frame so long frames are refused
  always_ff @(posedge spiClk) begin
    if (spiLatch) begin
      rxCount <= 6'h00;
    end else begin
      rxWord <= {spiDataIn, rxWord[31:1]};
      if (rxCount <= FRAME_COUNT_FULL) begin
        rxCount <= rxCount + 6'h01;
      end
    end
  end

  // read image only changes at frame ends, so it is stable here
  always_ff @(posedge spiClk) begin
    if (spiLatch) begin
      misoBit <= 1'b0;
    end else if (rxCount == 6'h00) begin
      misoBit <= readImage[0];
      txShift <= readImage[31:1];
    end else begin
      misoBit <= txShift[0];
      txShift <= {1'b0, txShift[30:1]};
    end
  end

  // quiet low between frames even before any link edge arrives
  assign spiDataOut = spiLatch ? 1'b0 : misoBit;

  // ****************************************
  // crossing into the system domain
  // ****************************************
  logic [SYNC_WIDTH-1:0] syncIn;
  logic [SYNC_WIDTH-1:0] syncLevels;
  logic frameSeen;
  logic latchRise;
  logic wordOk;
  logic writeHit;

  // the latch crosses inverted so the synchroniser's reset zero matches an idle link
  assign syncIn = {refPrimarySelected, refClockDetect, pllLockRaw,
                   oscClockDetect, auxClockDetect, !spiLatch};

  csmr_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(syncIn),
    .syncOut(syncLevels)
  );

  wire frameActS = syncLevels[SYNC_LATCH];
  wire auxS = syncLevels[SYNC_AUX];
  wire oscS = syncLevels[SYNC_OSC];
  wire lockS = syncLevels[SYNC_LOCK];
  wire refDetS = syncLevels[SYNC_REF_DET];
  wire refSelS = syncLevels[SYNC_REF_SEL];

  // edge detect on the second stage output only; both read idle after
  // reset, so leaving reset never looks like the end of a frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frameSeen <= 1'b0;
    end else begin
      frameSeen <= frameActS;
    end
  end

  // the frame has ended and the link clock has stopped shifting,
  // so the received word and count are stable when read here
  assign latchRise = frameSeen && !frameActS;
  assign wordOk = (rxCount == FRAME_COUNT_FULL) &&
                  (rxWord[ADDR_MSB:ADDR_LSB] == MODE_REG_ADDR);
  assign writeHit = latchRise && wordOk;

  // ****************************************
  // writable mode bits (volatile only)
  // ****************************************
  logic powerDownN;
  logic resetHoldN;
  logic testModeEnable;
  logic ioBlocksOffTest;
  logic statusPinCurrentRefSelect;
  logic holdToLockPinRoute;
  logic [3:0] statusRouteSelect;

  // read-only and reserved positions are simply not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      powerDownN <= POWER_DOWN_N_RESET;
      resetHoldN <= RESET_HOLD_N_RESET;
      testModeEnable <= TEST_MODE_RESET;
      ioBlocksOffTest <= IO_OFF_RESET;
      statusPinCurrentRefSelect <= CURRENT_REF_RESET;
      holdToLockPinRoute <= HOLD_ROUTE_RESET;
      statusRouteSelect <= STATUS_SEL_RESET;
    end else if (writeHit) begin
      powerDownN <= rxWord[POWER_DOWN_N_BIT];
      resetHoldN <= rxWord[RESET_HOLD_N_BIT];
      testModeEnable <= rxWord[TEST_MODE_BIT];
      ioBlocksOffTest <= rxWord[IO_OFF_BIT];
      statusPinCurrentRefSelect <= rxWord[CURRENT_REF_BIT];
      holdToLockPinRoute <= rxWord[HOLD_ROUTE_BIT];
      statusRouteSelect <= rxWord[STATUS_SEL_MSB:STATUS_SEL_LSB];
    end
  end

  // ****************************************
  // read image for the next frame
  // ****************************************
  logic [31:0] next_readImage;

  // status bits are a snapshot taken at each frame end; reserved read zero
  always_comb begin
    next_readImage = 32'h00000000;
    next_readImage[ADDR_MSB:ADDR_LSB] = MODE_REG_ADDR;
    next_readImage[AUX_DETECT_BIT] = auxS;
    next_readImage[OSC_DETECT_BIT] = oscS;
    next_readImage[PLL_LOCK_BIT] = lockS;
    next_readImage[POWER_DOWN_N_BIT] = powerDownN;
    next_readImage[RESET_HOLD_N_BIT] = resetHoldN;
    next_readImage[TEST_MODE_BIT] = testModeEnable;
    next_readImage[REVISION_MSB:REVISION_LSB] = REVISION_CODE;
    next_readImage[IO_OFF_BIT] = ioBlocksOffTest;
    next_readImage[CURRENT_REF_BIT] = statusPinCurrentRefSelect;
    next_readImage[HOLD_ROUTE_BIT] = holdToLockPinRoute;
    next_readImage[STATUS_SEL_MSB:STATUS_SEL_LSB] = statusRouteSelect;
  end

  // one cycle after the write so the image shows the new values;
  // the host must leave the latch high long enough for this update
  logic latchRiseDly;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latchRiseDly <= 1'b0;
      readImage <= 32'h00000000;
    end else begin
      latchRiseDly <= latchRise;
      if (latchRiseDly) begin
        readImage <= next_readImage;
      end
    end
  end

  // ****************************************
  // clock source steering
  // ****************************************
  wire ioOff = testModeEnable && ioBlocksOffTest;
  wire auxPinIsInput = pllSourceSelect || outSourceSelect;

  // pll and deterministic block follow the pll select, tree the output select
  assign pllFeedFromAux = pllSourceSelect;
  assign detBlockFromAux = pllSourceSelect;
  assign outputsFromAux = outSourceSelect;
  assign output9Enable = !auxPinIsInput && !ioOff;
  assign auxInputEnable = auxPinIsInput && !ioOff;
  assign oscInputEnable = !ioOff;
  assign outputBuffersEnable = !ioOff;
  assign dividersEnable = !ioOff;

  // ****************************************
  // device controls and indicator pins
  // ****************************************
  logic [3:0] routeSel;
  logic routedStatus;

  assign powerDown = !powerDownN;
  assign resetAssert = !resetHoldN && !holdFunctionSelect;
  assign holdAssert = !resetHoldN && holdFunctionSelect;
  assign lockPin = (testModeEnable && holdToLockPinRoute) ? holdAssert : lockS;
  assign routeSel = statusRouteSelect;
  // pin is a cmos driver unless the current reference mode is chosen
  assign statusPinOutEn_n = statusPinCurrentRefSelect;
  assign currentRefResistor = statusPinCurrentRefSelect;

  // status pin source; unlisted codes drive low
  always_comb begin
    unique case (routeSel)
      ROUTE_REF_DETECT: routedStatus = refDetS;
      ROUTE_PLL_LOCK: routedStatus = lockS;
      ROUTE_AUX_DETECT: routedStatus = auxS;
      ROUTE_OSC_DETECT: routedStatus = oscS;
      ROUTE_HOLD: routedStatus = holdAssert;
      ROUTE_REF_SELECT: routedStatus = refSelS;
      default: routedStatus = 1'b0;
    endcase
  end

  // registered so the pin data comes from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      statusPinOut <= 1'b0;
    end else begin
      statusPinOut <= routedStatus;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_frame_write;
    writeHit;
  endsequence

  sequence s_image_update;
    ##2 1'b1;
  endsequence

  a_out9_mode: assert property (
    output9Enable |-> !pllSourceSelect && !outSourceSelect && !ioOff)
    else $error("output 9 enabled while aux pin is selected");

  a_aux_pll_feed: assert property (
    (pllSourceSelect && !ioOff) |-> pllFeedFromAux && auxInputEnable && !output9Enable)
    else $error("aux pll feed not steered");

  a_tree_source: assert property (
    (outSourceSelect && !pllSourceSelect) |-> outputsFromAux && !pllFeedFromAux)
    else $error("tree source wrong for output select");

  a_pd_write: assert property (
    s_frame_write |=> powerDown == !$past(rxWord[POWER_DOWN_N_BIT]))
    else $error("power down not taken from written bit");

  a_frame_refuse: assert property (
    (latchRise && !wordOk) |=> $stable(powerDownN) && $stable(statusRouteSelect))
    else $error("refused frame changed mode bits");

  a_aux_snapshot: assert property (
    latchRise ##1 latchRiseDly |=> readImage[AUX_DETECT_BIT] == $past(auxS))
    else $error("aux detect snapshot wrong");

  a_rev_readback: assert property (
    latchRise |-> s_image_update ##0 readImage[REVISION_MSB:REVISION_LSB] == REVISION_CODE)
    else $error("revision code not read back");

  a_test_gate: assert property (
    !testModeEnable |-> oscInputEnable && dividersEnable && outputBuffersEnable)
    else $error("io disabled without test mode");

  a_lock_route: assert property (
    !(testModeEnable && holdToLockPinRoute) |-> lockPin == lockS)
    else $error("lock pin not showing lock");

  a_reset_values: assert property (
    $fell(rst) |-> !testModeEnable && powerDownN && resetHoldN &&
      statusRouteSelect == STATUS_SEL_RESET)
    else $error("mode bits wrong after reset");

  a_hold_select: assert property (
    !resetHoldN |-> (holdAssert == holdFunctionSelect) && (resetAssert != holdAssert))
    else $error("reset or hold function mis-selected");

  a_both_aux: assert property (
    (pllSourceSelect && outSourceSelect) |->
      pllFeedFromAux && outputsFromAux && detBlockFromAux && !output9Enable)
    else $error("aux not steered everywhere with both selects set");

  a_rh_write: assert property (
    s_frame_write |=> resetHoldN == $past(rxWord[RESET_HOLD_N_BIT]))
    else $error("reset or hold bit not taken from written bit");

  a_test_write: assert property (
    s_frame_write |=> testModeEnable == $past(rxWord[TEST_MODE_BIT]))
    else $error("test enable not taken from written bit");

  a_lock_snapshot: assert property (
    latchRise ##1 latchRiseDly |=> readImage[PLL_LOCK_BIT] == $past(lockS))
    else $error("lock snapshot wrong");

  a_status_route: assert property (
    (routeSel == ROUTE_PLL_LOCK) |=> statusPinOut == $past(lockS))
    else $error("status pin not showing lock when selected");

endmodule

/* logic/csmr_pkg.sv */
// constants for the clock source mux and serial mode register bank
package csmr_pkg;

  // ****************************************
  // frame and register layout
  // ****************************************
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_COUNT_FULL = 6'h20;
  localparam logic [3:0] MODE_REG_ADDR = 4'hc;
  localparam logic [31:0] MODE_REG_OFFSET = 32'h0000000c;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 3;
  localparam int AUX_DETECT_BIT = 8;
  localparam int OSC_DETECT_BIT = 9;
  localparam int PLL_LOCK_BIT = 10;
  localparam int POWER_DOWN_N_BIT = 11;
  localparam int RESET_HOLD_N_BIT = 12;
  localparam int TEST_MODE_BIT = 13;
  localparam int REVISION_LSB = 14;
  localparam int REVISION_MSB = 16;
  localparam int IO_OFF_BIT = 17;
  localparam int CURRENT_REF_BIT = 18;
  localparam int HOLD_ROUTE_BIT = 19;
  localparam int STATUS_SEL_LSB = 21;
  localparam int STATUS_SEL_MSB = 24;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic POWER_DOWN_N_RESET = 1'b1;
  localparam logic RESET_HOLD_N_RESET = 1'b1;
  localparam logic TEST_MODE_RESET = 1'b0;
  localparam logic IO_OFF_RESET = 1'b0;
  localparam logic CURRENT_REF_RESET = 1'b0;
  localparam logic HOLD_ROUTE_RESET = 1'b0;
  localparam logic [3:0] STATUS_SEL_RESET = 4'h2;
  // revision code value is arbitrary
  localparam logic [2:0] REVISION_CODE = 3'h1;

  // ****************************************
  // status pin routing codes
  // ****************************************
  localparam logic [3:0] ROUTE_REF_DETECT = 4'h0;
  localparam logic [3:0] ROUTE_PLL_LOCK = 4'h1;
  localparam logic [3:0] ROUTE_AUX_DETECT = 4'h2;
  localparam logic [3:0] ROUTE_OSC_DETECT = 4'h3;
  localparam logic [3:0] ROUTE_HOLD = 4'h4;
  localparam logic [3:0] ROUTE_REF_SELECT = 4'h8;

  // ****************************************
  // synchroniser layout
  // ****************************************
  localparam int SYNC_WIDTH = 6;
  localparam int SYNC_LATCH = 0;
  localparam int SYNC_AUX = 1;
  localparam int SYNC_OSC = 2;
  localparam int SYNC_LOCK = 3;
  localparam int SYNC_REF_DET = 4;
  localparam int SYNC_REF_SEL = 5;

endpackage

/* logic/csmr_sync.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module csmr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ****************************************
  // per-bit stages
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      // first stage feeds only the second stage
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage1 <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stage1 <= asyncIn[i];
          syncOut[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule

/* testbench/clock_source_mux_and_mode_register_bench.sv */
// self-checking bench for the clock source mux and mode register bank
`timescale 1ns/1ps
module clock_source_mux_and_mode_register_bench;
  import csmr_pkg::*;
  // ****************************************
  // signals and model state
  // ****************************************
  logic sys_clk, rst, spiClk, spiLatch, spiDataIn, spiDataOut;
  logic pllSourceSelect, outSourceSelect, holdFunctionSelect;
  logic auxClockDetect, oscClockDetect, pllLockRaw, refClockDetect, refPrimarySelected;
  logic pllFeedFromAux, outputsFromAux, detBlockFromAux, output9Enable, auxInputEnable;
  logic oscInputEnable, outputBuffersEnable, dividersEnable, powerDown, resetAssert;
  logic holdAssert, lockPin, statusPinOut, statusPinOutEn_n, currentRefResistor;
  int error_cnt, samples_checked, cycles;
  logic pdN, rhN, tm, ioOff, curRef, holdRoute;
  logic [3:0] sel;
  logic [31:0] expImage, word, rd;

  csmr_mode_bank dut_u (.sys_clk(sys_clk), .rst(rst), .spiClk(spiClk),
    .spiLatch(spiLatch), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .pllSourceSelect(pllSourceSelect), .outSourceSelect(outSourceSelect),
    .holdFunctionSelect(holdFunctionSelect), .auxClockDetect(auxClockDetect),
    .oscClockDetect(oscClockDetect), .pllLockRaw(pllLockRaw),
    .refClockDetect(refClockDetect), .refPrimarySelected(refPrimarySelected),
    .pllFeedFromAux(pllFeedFromAux), .outputsFromAux(outputsFromAux),
    .detBlockFromAux(detBlockFromAux), .output9Enable(output9Enable),
    .auxInputEnable(auxInputEnable), .oscInputEnable(oscInputEnable),
    .outputBuffersEnable(outputBuffersEnable), .dividersEnable(dividersEnable),
    .powerDown(powerDown), .resetAssert(resetAssert), .holdAssert(holdAssert),
    .lockPin(lockPin), .statusPinOut(statusPinOut), .statusPinOutEn_n(statusPinOutEn_n),
    .currentRefResistor(currentRefResistor));

  csmr_spi_host host_u (.spiClk(spiClk), .spiLatch(spiLatch), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut));

  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard: the full run needs roughly 4700 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // compares every steering, control and pin output with the model
  task automatic check_outs();
    logic io, hold, st, p, o;
    logic [31:0] s, e;
    p = pllSourceSelect;
    o = outSourceSelect;
    io = tm & ioOff;
    hold = !rhN & holdFunctionSelect;
    case (sel)
      ROUTE_REF_DETECT: st = refClockDetect;
      ROUTE_PLL_LOCK: st = pllLockRaw;
      ROUTE_AUX_DETECT: st = auxClockDetect;
      ROUTE_OSC_DETECT: st = oscClockDetect;
      ROUTE_HOLD: st = hold;
      ROUTE_REF_SELECT: st = refPrimarySelected;
      default: st = 1'b0;
    endcase
    s = 32'({pllFeedFromAux, detBlockFromAux, outputsFromAux, output9Enable, auxInputEnable});
    e = 32'({p, p, o, !(p | o) & !io, (p | o) & !io});
    check(s, e);
    s = 32'({oscInputEnable, outputBuffersEnable, dividersEnable});
    check(s, {29'h0, {3{!io}}});
    s = 32'({powerDown, resetAssert, holdAssert});
    check(s, 32'({!pdN, !rhN & !holdFunctionSelect, hold}));
    s = 32'({lockPin, statusPinOutEn_n, currentRefResistor});
    e = 32'({(tm & holdRoute) ? hold : pllLockRaw, curRef, curRef});
    check(s, e);
    check(32'(statusPinOut), 32'(st));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {pllSourceSelect, outSourceSelect, holdFunctionSelect, auxClockDetect} = 4'h0;
    {oscClockDetect, pllLockRaw, refClockDetect, refPrimarySelected} = 4'h0;
    {pdN, rhN, tm, ioOff, curRef, holdRoute} = 6'h30; // power-on values
    sel = STATUS_SEL_RESET;
    expImage = 32'h0; // first frame reads an empty image
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(49));
    repeat (4) @(posedge sys_clk);
    #2 rst = 1'b0;
    repeat (6) @(posedge sys_clk);
    check_outs();
    // every fourth frame has a wrong address, every fourth is one bit short
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk);
      #2;
      {pllSourceSelect, outSourceSelect, holdFunctionSelect, auxClockDetect,
        oscClockDetect, pllLockRaw, refClockDetect, refPrimarySelected} = 8'($urandom());
      repeat (6) @(posedge sys_clk);
      check_outs();
      word = $urandom();
      word[3:0] = (i % 4 == 2) ? 4'hb : MODE_REG_ADDR;
      word[24:21] = {i[4:2], i[0]}; // walks all sixteen route codes
      host_u.frame(word, (i % 4 == 3) ? 31 : 32, rd);
      check(rd, expImage);
      if (i % 4 < 2) begin
        {tm, rhN, pdN} = word[13:11];
        {holdRoute, curRef, ioOff} = word[19:17];
        sel = word[24:21];
      end
      expImage = {7'h0, sel, 1'b0, holdRoute, curRef, ioOff, REVISION_CODE, tm, rhN, pdN,
        pllLockRaw, oscClockDetect, auxClockDetect, 4'h0, MODE_REG_ADDR};
      repeat (16) @(posedge sys_clk);
    end
    check_outs();
    report_and_stop();
  end
endmodule

/* testbench/csmr_spi_host.sv */
// behavioural serial host that shifts frames into the mode bank
`timescale 1ns/1ps
module csmr_spi_host (
  // serial link towards the device
  output logic spiClk,
  output logic spiLatch,
  output logic spiDataIn,
  input wire logic spiDataOut
);
  // ****************************************
  // link idle state and frame task
  // ****************************************
  // link clock is parked low between frames, latch idles high
  initial begin
    spiClk = 1'b0;
    spiLatch = 1'b1;
    spiDataIn = 1'b0;
  end

  // shifts n bits of w, bit 0 first, and collects the readback word
  task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    // one pulse with the latch high clears the shifter, which has no reset
    #13 spiClk = 1'b1;
    #40 spiClk = 1'b0;
    #40 spiLatch = 1'b0;
    for (int i = 0; i < n; i++) begin
      spiDataIn = w[i];
      #40 spiClk = 1'b1;
      #40 spiClk = 1'b0;
      r[i] = spiDataOut; // readback bit is stable on the falling edge
    end
    #40 spiLatch = 1'b1;
    // released data line flips so a stale value never looks valid
    spiDataIn = ~spiDataIn;
    // idle gap far beyond the four system cycles the bank needs
    #400;
  endtask
endmodule
